// file: hw/sfb_flash_front.sv
`timescale 1ns/1ps
module sfb_flash_front
   import sfb_pkg::*;
#(
   parameter int BUSY_CYCLES = STATUS_WRITE_CYC
)(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   sck,
   input  wire logic                   cs_n,
   input  wire logic [3:0]             lane_in,
   output logic      [3:0]             lane_out,
   output logic      [3:0]             lane_oe_n,
   input  wire logic                   array_busy,
   input  wire logic                   array_done,
   output logic                        array_req,
   output logic                        array_allowed,
   output logic      [7:0]             array_cmd,
   output logic      [sfb_pkg::ADDR_BITS-1:0] array_addr,
   output logic      [10:0]            sector_index,
   output logic      [7:0]             block32_index,
   output logic      [6:0]             block64_index,
   output logic      [7:0]             device_status,
   output logic      [sfb_pkg::BP_WIDTH-1:0] protect_level,
   output logic                        quad_lane_enable,
   output logic                        four_lane_command_mode
);
   import sfb_pkg::*;

   initial begin
      if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin
         $error("BUSY_CYCLES out of range");
      end
   end

   sfb_link_if link ();

   sfb_lane_shifter u_shifter (
      .clock     (clock),
      .rst_n     (rst_n),
      .sck       (sck),
      .cs_n      (cs_n),
      .lane_in   (lane_in),
      .lane_out  (lane_out),
      .lane_oe_n (lane_oe_n),
      .link      (link.shifter)
   );

   sfb_state_type                 state_ff;
   logic [7:0]                    cmd_ff;
   logic [7:0]                    wr_data_ff;
   logic [1:0]                    addr_cnt_ff;
   logic [ADDR_BITS-1:0]          addr_ff;
   logic                          array_req_ff;
   logic                          array_allowed_ff;
   logic                          wel_ff;
   logic                          lock_ff;
   logic                          qe_ff;
   logic [BP_WIDTH-1:0]           bp_ff;
   logic                          quad_cmd_ff;
   logic [15:0]                   busy_cnt_ff;
   logic [7:0]                    status_ff;
   logic                          tx_en_ff;
   logic                          busy;
   logic                          armed_end;
   logic                          status_write_ok;
   logic                          status_done;
   logic                          set_evt;
   logic                          clear_evt;

   // ----------------------------------------------------------------
   // Command sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= ST_CMD;
         cmd_ff      <= 8'h00;
         wr_data_ff  <= STATUS_RESET;
         addr_cnt_ff <= 2'h0;
         addr_ff     <= '0;
      end else if (!link.selected) begin
         state_ff    <= ST_CMD;
         addr_cnt_ff <= 2'h0;
      end else if (link.rx_strobe) begin
         case (state_ff)
            ST_CMD: begin
               cmd_ff <= link.rx_byte;
               case (link.rx_byte)
                  OP_STATUS_READ:  state_ff <= ST_READ;
                  OP_STATUS_WRITE: state_ff <= ST_WDATA;
                  OP_SET_LATCH,
                  OP_CLEAR_LATCH,
                  OP_QUAD_ENTER,
                  OP_QUAD_EXIT:    state_ff <= ST_ARMED;
                  default:         state_ff <= ST_ADDR;
               endcase
            end
            ST_WDATA: begin
               wr_data_ff <= link.rx_byte;
               state_ff   <= ST_ARMED;
            end
            ST_ADDR: begin
               addr_ff     <= {addr_ff[ADDR_BITS-9:0], link.rx_byte};
               addr_cnt_ff <= addr_cnt_ff + 2'h1;
               if (addr_cnt_ff == 2'(ADDR_BYTES - 1)) begin
                  state_ff <= ST_IGNORE;
               end
            end
            ST_READ:   state_ff <= ST_READ;
            ST_ARMED:  state_ff <= ST_IGNORE;
            ST_IGNORE: state_ff <= ST_IGNORE;
            default:   state_ff <= ST_IGNORE;
         endcase
      end
   end

   // Address phase done: hand the command to the array engine
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         array_req_ff     <= 1'b0;
         array_allowed_ff <= 1'b0;
      end else begin
         array_req_ff <= link.selected && link.rx_strobe && state_ff == ST_ADDR
                         && addr_cnt_ff == 2'(ADDR_BYTES - 1);
         if (link.selected && link.rx_strobe && state_ff == ST_ADDR) begin
            array_allowed_ff <= !busy && wel_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // Commands executed when chip select rises
   // ----------------------------------------------------------------
   assign armed_end       = link.frame_end && state_ff == ST_ARMED;
   // Lock only bites while the protect pin is low
   assign status_write_ok = armed_end && cmd_ff == OP_STATUS_WRITE && !busy && wel_ff
                            && !(lock_ff && !link.wp_level);
   assign set_evt         = armed_end && cmd_ff == OP_SET_LATCH;
   assign clear_evt       = armed_end && cmd_ff == OP_CLEAR_LATCH;
   assign status_done     = busy_cnt_ff == 16'h0001;
   assign busy            = busy_cnt_ff != 16'h0000 || array_busy;

   // Nonvolatile cells sit behind these; reset restores factory zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lock_ff <= 1'b0;
         qe_ff   <= 1'b0;
         bp_ff   <= BP_RESET;
      end else if (status_write_ok) begin
         lock_ff <= wr_data_ff[STAT_LOCK_BIT];
         qe_ff   <= wr_data_ff[STAT_QE_BIT];
         bp_ff   <= wr_data_ff[STAT_BP_MSB:STAT_BP_LSB];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_ff <= 16'h0000;
      end else if (status_write_ok) begin
         busy_cnt_ff <= 16'(BUSY_CYCLES);
      end else if (busy_cnt_ff != 16'h0000) begin
         busy_cnt_ff <= busy_cnt_ff - 16'h0001;
      end
   end

   // Set wins if it lands with a completion; status data bit 1 is unused
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wel_ff <= 1'b0;
      end else if (set_evt) begin
         wel_ff <= 1'b1;
      end else if (clear_evt || status_done || array_done) begin
         wel_ff <= 1'b0;
      end
   end

   // Four-lane command mode needs the quad enable bit first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         quad_cmd_ff <= 1'b0;
      end else if (armed_end && cmd_ff == OP_QUAD_ENTER && qe_ff) begin
         quad_cmd_ff <= 1'b1;
      end else if (armed_end && cmd_ff == OP_QUAD_EXIT) begin
         quad_cmd_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Status byte and read-out
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= STATUS_RESET;
      end else begin
         status_ff[STAT_LOCK_BIT]             <= lock_ff;
         status_ff[STAT_QE_BIT]               <= qe_ff;
         status_ff[STAT_BP_MSB:STAT_BP_LSB]   <= bp_ff;
         status_ff[STAT_WEL_BIT]              <= wel_ff;
         status_ff[STAT_BUSY_BIT]             <= busy;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_en_ff <= 1'b0;
      end else begin
         tx_en_ff <= link.selected && (state_ff == ST_READ);
      end
   end

   assign link.tx_byte    = status_ff;
   assign link.tx_en      = tx_en_ff;
   assign link.quad_mode  = quad_cmd_ff;
   assign link.lanes_wide = qe_ff;

   // ----------------------------------------------------------------
   // Outputs and address partition
   // ----------------------------------------------------------------
   assign array_req              = array_req_ff;
   assign array_allowed          = array_allowed_ff;
   assign array_cmd              = cmd_ff;
   assign array_addr             = addr_ff & ADDR_TOP;
   assign sector_index           = addr_ff[ADDR_MSB_USED:SECTOR_LSB];
   assign block32_index          = addr_ff[ADDR_MSB_USED:BLOCK32_LSB];
   assign block64_index          = addr_ff[ADDR_MSB_USED:BLOCK64_LSB];
   assign device_status          = status_ff;
   assign protect_level          = bp_ff;
   assign quad_lane_enable       = qe_ff;
   assign four_lane_command_mode = quad_cmd_ff;

endmodule : sfb_flash_front

// file: hw/sfb_pkg.sv
package sfb_pkg;

   // ----------------------------------------------------------------
   // Status byte layout
   // ----------------------------------------------------------------
   localparam int                STAT_BUSY_BIT   = 0;
   localparam int                STAT_WEL_BIT    = 1;
   localparam int                STAT_BP_LSB     = 2;
   localparam int                STAT_BP_MSB     = 5;
   localparam int                STAT_QE_BIT     = 6;
   localparam int                STAT_LOCK_BIT   = 7;
   localparam int                BP_WIDTH        = 4;
   localparam logic [7:0]        STATUS_RESET    = 8'h00;
   localparam logic [3:0]        BP_RESET        = 4'h0;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0]        OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0]        OP_CLEAR_LATCH  = 8'h04;
   localparam logic [7:0]        OP_STATUS_READ  = 8'h05;
   localparam logic [7:0]        OP_SET_LATCH    = 8'h06;
   localparam logic [7:0]        OP_QUAD_ENTER   = 8'h35;
   localparam logic [7:0]        OP_QUAD_EXIT    = 8'hf5;

   // ----------------------------------------------------------------
   // Lanes and address partition
   // ----------------------------------------------------------------
   localparam int                LANE_SI         = 0;
   localparam int                LANE_SO         = 1;
   localparam int                LANE_WP         = 2;
   localparam int                LANE_PAUSE      = 3;
   localparam int                ADDR_BITS       = 24;
   localparam int                ADDR_BYTES      = 3;
   localparam logic [23:0]       ADDR_TOP        = 24'h7fffff;
   localparam int                SECTOR_LSB      = 12;
   localparam int                BLOCK32_LSB     = 15;
   localparam int                BLOCK64_LSB     = 16;
   localparam int                ADDR_MSB_USED   = 22;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int                CLOCK_MHZ       = 200;
   localparam int                STATUS_WRITE_NS = 2000;
   localparam int                STATUS_WRITE_CYC = (STATUS_WRITE_NS * CLOCK_MHZ + 999) / 1000;

   typedef enum logic [5:0] {
      ST_CMD    = 6'b000001,
      ST_ADDR   = 6'b000010,
      ST_WDATA  = 6'b000100,
      ST_ARMED  = 6'b001000,
      ST_READ   = 6'b010000,
      ST_IGNORE = 6'b100000
   } sfb_state_type;

endpackage : sfb_pkg

// file: hw/sfb_link_if.sv
`timescale 1ns/1ps
interface sfb_link_if;
   logic       sck_rise;
   logic       sck_fall;
   logic       selected;
   logic       frame_end;
   logic [7:0] rx_byte;
   logic       rx_strobe;
   logic       wp_level;
   logic [7:0] tx_byte;
   logic       tx_en;
   logic       quad_mode;
   logic       lanes_wide;

   modport shifter (
      output sck_rise, sck_fall, selected, frame_end, rx_byte, rx_strobe, wp_level,
      input  tx_byte, tx_en, quad_mode, lanes_wide
   );
   modport core (
      input  sck_rise, sck_fall, selected, frame_end, rx_byte, rx_strobe, wp_level,
      output tx_byte, tx_en, quad_mode, lanes_wide
   );
endinterface : sfb_link_if

// file: hw/sfb_lane_shifter.sv
`timescale 1ns/1ps
module sfb_lane_shifter
   import sfb_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic [3:0] lane_in,
   output logic      [3:0] lane_out,
   output logic      [3:0] lane_oe_n,
   sfb_link_if.shifter     link
);
   import sfb_pkg::*;

   logic [1:0] sck_sync_ff;
   logic [1:0] cs_sync_ff;
   logic [3:0] lane_s1_ff;
   logic [3:0] lane_s2_ff;
   logic       sck_prev_ff;
   logic       sel_prev_ff;
   logic [2:0] rx_cnt_ff;
   logic [7:0] rx_shift_ff;
   logic [7:0] rx_byte_ff;
   logic       rx_strobe_ff;
   logic [2:0] tx_idx_ff;
   logic [7:0] tx_hold_ff;
   logic [3:0] lane_out_ff;
   logic [3:0] lane_oe_n_ff;
   logic       hold;
   logic       sel;
   logic [7:0] nxt_rx_shift;
   logic [2:0] nxt_rx_cnt;
   logic [7:0] tx_cur;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sck_sync_ff <= 2'h0;
         cs_sync_ff  <= 2'h3;
         lane_s1_ff  <= 4'hf;
         lane_s2_ff  <= 4'hf;
      end else begin
         sck_sync_ff <= {sck_sync_ff[0], sck};
         cs_sync_ff  <= {cs_sync_ff[0], cs_n};
         lane_s1_ff  <= lane_in;
         lane_s2_ff  <= lane_s1_ff;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_ff <= 1'b0;
         sel_prev_ff <= 1'b0;
      end else begin
         sck_prev_ff <= sck_sync_ff[1];
         sel_prev_ff <= sel;
      end
   end

   assign sel            = !cs_sync_ff[1];
   // Pause pin only counts while it is not a data lane
   assign hold           = sel && !link.lanes_wide && !link.quad_mode && !lane_s2_ff[LANE_PAUSE];
   // Either idle level works: only edges inside the frame are used
   assign link.sck_rise  = sel && !hold && sck_sync_ff[1] && !sck_prev_ff;
   assign link.sck_fall  = sel && !hold && !sck_sync_ff[1] && sck_prev_ff;
   assign link.selected  = sel;
   assign link.frame_end = sel_prev_ff && !sel;
   assign link.rx_byte   = rx_byte_ff;
   assign link.rx_strobe = rx_strobe_ff;
   assign link.wp_level  = link.lanes_wide ? 1'b1 : lane_s2_ff[LANE_WP];

   // ----------------------------------------------------------------
   // Receive
   // ----------------------------------------------------------------
   always_comb begin
      if (link.quad_mode) begin
         nxt_rx_shift = {rx_shift_ff[3:0], lane_s2_ff};
         nxt_rx_cnt   = rx_cnt_ff + 3'h4;
      end else begin
         nxt_rx_shift = {rx_shift_ff[6:0], lane_s2_ff[LANE_SI]};
         nxt_rx_cnt   = rx_cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt_ff    <= 3'h0;
         rx_shift_ff  <= 8'h00;
         rx_byte_ff   <= 8'h00;
         rx_strobe_ff <= 1'b0;
      end else begin
         rx_strobe_ff <= 1'b0;
         if (!sel) begin
            rx_cnt_ff <= 3'h0;
         end else if (link.sck_rise) begin
            rx_shift_ff <= nxt_rx_shift;
            rx_cnt_ff   <= nxt_rx_cnt;
            if (nxt_rx_cnt == 3'h0) begin
               rx_byte_ff   <= nxt_rx_shift;
               rx_strobe_ff <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmit, byte latched at its first bit so it never tears
   // ----------------------------------------------------------------
   assign tx_cur = (tx_idx_ff == 3'h7) ? link.tx_byte : tx_hold_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_idx_ff   <= 3'h7;
         tx_hold_ff  <= 8'h00;
         lane_out_ff <= 4'h0;
      end else if (!sel || !link.tx_en) begin
         tx_idx_ff <= 3'h7;
      end else if (link.sck_fall) begin
         if (tx_idx_ff == 3'h7) begin
            tx_hold_ff <= link.tx_byte;
         end
         if (link.quad_mode) begin
            lane_out_ff <= tx_idx_ff[2] ? tx_cur[7:4] : tx_cur[3:0];
            tx_idx_ff   <= tx_idx_ff - 3'h4;
         end else begin
            lane_out_ff[LANE_SO] <= tx_cur[tx_idx_ff];
            tx_idx_ff            <= tx_idx_ff - 3'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lane_oe_n_ff <= 4'hf;
      end else if (sel && link.tx_en && !hold) begin
         lane_oe_n_ff <= link.quad_mode ? 4'h0 : 4'hd;
      end else begin
         lane_oe_n_ff <= 4'hf;
      end
   end

   assign lane_out  = lane_out_ff;
   assign lane_oe_n = lane_oe_n_ff;

endmodule : sfb_lane_shifter

// file: dv/sfb_flash_front_monitor.sv
`timescale 1ns/1ps
module sfb_flash_front_monitor
   import sfb_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        cs_n,
   input wire logic [3:0]  lane_oe_n,
   input wire logic        array_busy,
   input wire logic        array_done,
   input wire logic        array_req,
   input wire logic [23:0] array_addr,
   input wire logic [10:0] sector_index,
   input wire logic [7:0]  block32_index,
   input wire logic [6:0]  block64_index,
   input wire logic [7:0]  device_status,
   input wire logic [3:0]  protect_level,
   input wire logic        quad_lane_enable,
   input wire logic        four_lane_command_mode
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Status byte trails its sources by one register stage
   a_status_fields: assert property (device_status[6:2] == $past({quad_lane_enable, protect_level}))
      else $error("status fields differ");
   a_oe_released: assert property (cs_n [*8] |-> lane_oe_n == 4'hf)
      else $error("lanes driven while deselected");
   a_single_lane: assert property (!four_lane_command_mode && !$past(four_lane_command_mode) |->
      lane_oe_n[0] && (&lane_oe_n[3:2])) else $error("extra lane driven in single-lane mode");
   a_addr_top: assert property (array_addr <= ADDR_TOP) else $error("address above top");
   a_index_split: assert property ($stable(array_addr) |-> sector_index == array_addr[22:12]
      && block32_index == array_addr[22:15] && block64_index == array_addr[22:16])
      else $error("sector or block index wrong");
   a_busy_shows: assert property (array_busy |-> ##[1:3] device_status[0])
      else $error("busy flag missing");
   a_done_clears: assert property (array_done && cs_n && $past(cs_n, 8) |->
      ##[1:3] !device_status[1]) else $error("latch kept after completion");
   a_latch_cmd_only: assert property ($rose(device_status[1]) |-> cs_n && $past(cs_n))
      else $error("latch set inside a frame");
   a_retained_end: assert property ($changed(device_status[7:2]) |-> cs_n && $past(cs_n, 2))
      else $error("retained bits changed inside a frame");
   c_read_out: cover property (!lane_oe_n[1]);
   c_array_req: cover property (array_req);
   c_write_busy: cover property (device_status[0] && !array_busy);
endmodule : sfb_flash_front_monitor

// file: dv/sfb_spi_master.sv
`timescale 1ns/1ps
module sfb_spi_master (
   output logic      sck,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   logic mode3;
   initial begin
      mode3 = 1'b0;
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Clock idles at the mode's level before select drops
   task automatic open_frame(input logic m3);
      mode3 = m3;
      sck = m3;
      #48 cs_n = 1'b0;
      #48;
   endtask : open_frame
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         mosi = tx[i];
         #24 sck = 1'b1;
         rx[i] = miso;
         #24;
      end
   endtask : shift
   task automatic close_frame();
      sck = mode3;
      #24 cs_n = 1'b1;
      #200;
   endtask : close_frame
endmodule : sfb_spi_master

// file: dv/serial_flash_bus_status_tb.sv
`timescale 1ns/1ps
module serial_flash_bus_status_tb;
   import sfb_pkg::*;
   logic        clock, rst_n, sck, cs_n, mosi, tog, wp_n, m3;
   logic        array_busy, array_done, array_req, array_allowed;
   logic        quad_lane_enable, four_lane_command_mode;
   logic [3:0]  lane_in, lane_out, lane_oe_n, protect_level;
   logic [7:0]  array_cmd, device_status, block32_index, r0, r1, d;
   logic [23:0] array_addr, a;
   logic [10:0] sector_index;
   logic [6:0]  block64_index;
   logic [31:0] e;
   logic [31:0] q[$];
   int          errors, samples_checked, seed, exp_stat;

   initial clock = 1'b0;
   always #2.5 clock = ~clock;
   initial tog = 1'b0;
   always @(posedge clock) tog <= ~tog;
   // Undriven lines wander so a stale level is never mistaken for data
   assign lane_in = {1'b1, wp_n, lane_oe_n[1] ? tog : lane_out[1], cs_n ? tog : mosi};

   sfb_spi_master i_sfb_spi_master (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(lane_in[1]));
   sfb_flash_front #(.BUSY_CYCLES(4)) i_sfb_flash_front (
      .clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .lane_in(lane_in),
      .lane_out(lane_out), .lane_oe_n(lane_oe_n), .array_busy(array_busy),
      .array_done(array_done), .array_req(array_req), .array_allowed(array_allowed),
      .array_cmd(array_cmd), .array_addr(array_addr), .sector_index(sector_index),
      .block32_index(block32_index), .block64_index(block64_index),
      .device_status(device_status), .protect_level(protect_level),
      .quad_lane_enable(quad_lane_enable), .four_lane_command_mode(four_lane_command_mode));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   // n bytes of dd follow the opcode; last two echoes land in r1, r0
   task automatic frame(input logic [7:0] op, input logic [7:0] dd, input int n);
      i_sfb_spi_master.open_frame(m3);
      i_sfb_spi_master.shift(op, r0);
      for (int k = 0; k < n; k++) begin
         r1 = r0;
         i_sfb_spi_master.shift(dd, r0);
      end
      i_sfb_spi_master.close_frame();
   endtask : frame
   task automatic expect_status();
      frame(OP_STATUS_READ, 8'h00, 2);
      check(r1, exp_stat);
      check(r0, exp_stat);
   endtask : expect_status

   // Sampled mid-cycle so the registered pulse is settled
   always @(negedge clock) begin
      if (array_req === 1'b1) begin
         e = q.pop_front();
         check({7'h00, array_allowed, array_addr}, e);
         check(array_cmd, 8'h20);
         check(sector_index, e[22:12]);
         check({block32_index, 1'b0, block64_index}, {e[22:15], 1'b0, e[22:16]});
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 32'h6ae6;
      errors = 0;
      samples_checked = 0;
      exp_stat = 0;
      m3 = 1'b0;
      wp_n = 1'b1;
      array_busy = 1'b0;
      array_done = 1'b0;
      rst_n = 1'b0;
      repeat (4) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      expect_status();
      for (int i = 0; i < 6; i++) begin
         m3 = i[0];
         d = $random(seed);
         frame(OP_STATUS_WRITE, d, 1);
         expect_status();
         frame(OP_SET_LATCH, 8'h00, 0);
         exp_stat = exp_stat | 32'h2;
         expect_status();
         frame(OP_STATUS_WRITE, d, 1);
         exp_stat = d & 8'hfc;
         expect_status();
         check(protect_level, d[5:2]);
         check(quad_lane_enable, d[6]);
      end
      frame(OP_SET_LATCH, 8'h00, 0);
      frame(OP_STATUS_WRITE, 8'h80, 1);
      wp_n = 1'b0;
      frame(OP_SET_LATCH, 8'h00, 0);
      frame(OP_STATUS_WRITE, 8'h3c, 1);
      exp_stat = 32'h82;
      expect_status();
      frame(OP_CLEAR_LATCH, 8'h00, 0);
      exp_stat = 32'h80;
      expect_status();
      frame(OP_QUAD_ENTER, 8'h00, 0);
      check(four_lane_command_mode, 1'b0);
      wp_n = 1'b1;
      frame(OP_SET_LATCH, 8'h00, 0);
      frame(OP_STATUS_WRITE, 8'h00, 1);
      @(posedge clock);
      #1 array_busy = 1'b1;
      frame(OP_SET_LATCH, 8'h00, 0);
      frame(OP_STATUS_WRITE, 8'h0c, 1);
      exp_stat = 32'h3;
      expect_status();
      @(posedge clock);
      #1 array_busy = 1'b0;
      exp_stat = 32'h2;
      for (int i = 0; i < 2; i++) begin
         a = $random(seed);
         q.push_back({7'h00, exp_stat[1], a & ADDR_TOP});
         i_sfb_spi_master.open_frame(m3);
         i_sfb_spi_master.shift(8'h20, r0);
         i_sfb_spi_master.shift(a[23:16], r0);
         i_sfb_spi_master.shift(a[15:8], r0);
         i_sfb_spi_master.shift(a[7:0], r0);
         i_sfb_spi_master.close_frame();
         @(posedge clock);
         #1 array_done = 1'b1;
         @(posedge clock);
         #1 array_done = 1'b0;
         exp_stat = 0;
         expect_status();
      end
      check(q.size(), 0);
      give_verdict();
   end

   initial begin
      #400us;
      errors++;
      give_verdict();
   end
endmodule : serial_flash_bus_status_tb

bind sfb_flash_front sfb_flash_front_monitor i_sfb_flash_front_monitor (
   .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .lane_oe_n(lane_oe_n),
   .array_busy(array_busy), .array_done(array_done), .array_req(array_req),
   .array_addr(array_addr), .sector_index(sector_index), .block32_index(block32_index),
   .block64_index(block64_index), .device_status(device_status),
   .protect_level(protect_level), .quad_lane_enable(quad_lane_enable),
   .four_lane_command_mode(four_lane_command_mode));
